/* File: logic/mbrm_pkg.sv */
// Package: constants and carrier types of the measurement register map
package mbrm_pkg;

  // Unit identifiers
  localparam logic [7:0]  UNIT_XMTR       = 8'hF0;        // Transmitter itself
  localparam logic [7:0]  UNIT_PROBE1     = 8'hF1;        // Probe on first terminal
  localparam logic [7:0]  UNIT_PROBE2     = 8'hF2;        // Probe on second terminal

  // Function codes
  localparam logic [7:0]  FC_READ_HOLD    = 8'h03;        // Read holding registers
  localparam logic [7:0]  FC_DEV_IDENT    = 8'h2B;        // Encapsulated transport
  localparam logic [7:0]  MEI_DEV_IDENT   = 8'h0E;        // Read device identification

  // Exception codes
  localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;        // Function not supported
  localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;        // Address not implemented
  localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;        // Bad quantity or subcode
  localparam logic [7:0]  EXC_NO_PATH     = 8'h0A;        // Unit not served

  // Register addresses on the wire (register number minus one)
  localparam logic [15:0] ADDR_PRESS_F    = 16'h002A;     // Pressure float, low word
  localparam logic [15:0] ADDR_AIN_ACT_F  = 16'h0034;     // Input current float, low word
  localparam logic [15:0] ADDR_AIN_VAL_F  = 16'h0036;     // Validated current float, low word
  localparam logic [15:0] ADDR_PRESS_I    = 16'h0115;     // Pressure integer
  localparam logic [15:0] ADDR_AIN_ACT_I  = 16'h011A;     // Input current integer
  localparam logic [15:0] ADDR_AIN_VAL_I  = 16'h011B;     // Validated current integer
  localparam logic [15:0] ADDR_STEP       = 16'h0001;     // Offset of the high word

  // Quantity limits for one read
  localparam logic [15:0] QTY_MIN         = 16'h0001;
  localparam logic [15:0] QTY_MAX         = 16'h007D;

  // Integer scaling and fixed-point input format
  localparam int          FRAC_BITS       = 16;           // Fraction bits of fixed inputs
  localparam logic [15:0] SCALE_PRESS     = 16'h000A;     // Pressure times 10
  localparam logic [15:0] SCALE_AIN       = 16'h03E8;     // Current times 1000

  // Integer codes
  localparam logic [15:0] CODE_MAX        = 16'h7FFF;     // 32767 or larger
  localparam logic [15:0] CODE_NA         = 16'h8000;     // Not available
  localparam logic [15:0] CODE_MIN        = 16'h8001;     // -32767 or smaller

  // Analog input valid window in Q16.16 mA
  localparam logic signed [31:0] AIN_MIN_Q = 32'sh0003_CCCD; // 3.8 mA
  localparam logic signed [31:0] AIN_MAX_Q = 32'sh0014_8000; // 20.5 mA

  // Quiet NaN for unavailable floats
  localparam logic [31:0] FLOAT_NAN       = 32'h7FC0_0000;

  // Identification words (arbitrary neutral values)
  localparam logic [15:0] ID_VENDOR       = 16'h0A5A;     // Arbitrary
  localparam logic [15:0] ID_PRODUCT      = 16'h0001;     // Arbitrary
  localparam logic [15:0] ID_REVISION     = 16'h0100;     // Arbitrary
  localparam logic [15:0] ID_WORDS        = 16'h0003;

  // Request as decoded from the protocol data unit
  typedef struct packed {
    logic [7:0]  unit;
    logic [7:0]  func;
    logic [7:0]  meiType;
    logic [15:0] addr;
    logic [15:0] qty;
  } mbrm_req_t;

  // One answer word; on an exception data[7:0] is the code
  typedef struct packed {
    logic [15:0] data;
    logic        last;
    logic        exc;
  } mbrm_rsp_t;

  // Request forwarded to a probe
  typedef struct packed {
    logic        sel;
    logic [15:0] addr;
    logic [15:0] qty;
  } mbrm_probe_req_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_SEND  = 3'b010,
    ST_IDENT = 3'b011,
    ST_PROBE = 3'b100,
    ST_EXC   = 3'b101
  } mbrm_state_t;

endpackage

/* File: logic/mbrm_int16_encode.sv */
// Fixed-point value to scaled saturated 16-bit signed register code
`timescale 1ns/1ps
`default_nettype none
module mbrm_int16_encode #(
  parameter logic [15:0] SCALE = mbrm_pkg::SCALE_PRESS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Value in
  input  wire logic signed [31:0] fixedIn,
  input  wire logic              avail,
  // Code out
  output logic        [15:0]     codeOut
);

  logic signed [48:0] scaled;   // Value times scale, fraction dropped

  // Scale the fixed-point value
  always_comb
  begin
    scaled = ($signed(fixedIn) * $signed({1'b0, SCALE})) >>> mbrm_pkg::FRAC_BITS;
  end

  // Register the code with saturation and not-available marking
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      codeOut <= mbrm_pkg::CODE_NA;
    else if (!avail)
      codeOut <= mbrm_pkg::CODE_NA;
    else if (scaled >= 49'sd32767)
      codeOut <= mbrm_pkg::CODE_MAX;
    else if (scaled <= -49'sd32767)
      codeOut <= mbrm_pkg::CODE_MIN;
    else
      codeOut <= scaled[15:0];
  end

  property p_na;
    @(posedge clk_sys) disable iff (!reset_n)
    !avail |=> codeOut == 16'h8000;
  endproperty
  a_na: assert property (p_na) else $error("missing value not coded 8000");

  // Sampled reset_n keeps out the release edge, where the code still reads 8000
  property p_high;
    @(posedge clk_sys) disable iff (!reset_n)
    reset_n && avail && scaled >= 49'sd32767 |=> codeOut == 16'h7FFF;
  endproperty
  a_high: assert property (p_high) else $error("high value not saturated");

  property p_low;
    @(posedge clk_sys) disable iff (!reset_n)
    reset_n && avail && scaled <= -49'sd32767 |=> codeOut == 16'h8001;
  endproperty
  a_low: assert property (p_low) else $error("low value not saturated");

  property p_mid;
    @(posedge clk_sys) disable iff (!reset_n)
    reset_n && avail && scaled < 49'sd32767 && scaled > -49'sd32767
      |=> codeOut == $past(scaled[15:0]);
  endproperty
  a_mid: assert property (p_mid) else $error("in-range value altered");

endmodule // mbrm_int16_encode
`default_nettype wire

/* File: logic/mbrm_register_map.sv */
// Protocol register map of the measurement transmitter with probe routing
`timescale 1ns/1ps
`default_nettype none
// Function
// - Units 240, 241, 242: transmitter, probe one, two
// - Read holding registers served for all three units
// - Device identification answered only under unit 240
// - Floats are binary32 in two registers
// - Low word at listed address, high next
// - Values 32767 and above saturate to 7FFF
// - Unavailable integer quantities read 8000
// - -32767 and below give 8001, else two's complement
// - Integer registers hold value times scale factor
// - Wire address equals register number minus one
// - Measurements only under 240 with option fitted
// - Read-only floats: pressure, current, validated current
// - Validated current NaN or 8000 outside window
// - Read-only integers: pressure x10, current x1000
// - Actual current integer is not range validated
module mbrm_register_map (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  // Request
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire mbrm_pkg::mbrm_req_t       req,
  // Response
  output logic                           rspValid,
  output mbrm_pkg::mbrm_rsp_t            rsp,
  // Fitted options
  input  wire logic                      baroFitted,
  input  wire logic                      analogFitted,
  // Measurements
  input  wire logic [31:0]               pressureFloat,
  input  wire logic signed [31:0]        pressureFixed,
  input  wire logic                      pressureAvail,
  input  wire logic [31:0]               ainFloat,
  input  wire logic signed [31:0]        ainFixed,
  input  wire logic                      ainAvail,
  // Probe path
  output logic                           probeReqValid,
  output mbrm_pkg::mbrm_probe_req_t      probeReq,
  input  wire logic                      probeRspValid,
  input  wire mbrm_pkg::mbrm_rsp_t       probeRsp
);

  mbrm_pkg::mbrm_state_t state_r;        // Controller state
  mbrm_pkg::mbrm_state_t state_nxt;      // Next state on accept
  mbrm_pkg::mbrm_req_t   req_r;          // Latched request
  logic [15:0]           cnt_r;          // Word index within the read
  logic [7:0]            excCode_r;      // Pending exception code
  logic [7:0]            excCode_nxt;    // Exception code chosen on accept
  logic                  reqAccept;      // Request taken this cycle
  logic                  ainInRange;     // Current inside valid window
  logic [15:0]           curAddr;        // Address of current word
  logic                  lastWord;       // Current word is the final one
  logic                  hitOk;          // Current address is served
  logic [15:0]           hitWord;        // Data of current address
  logic [15:0]           idWord;         // Identification word
  logic [31:0]           snapPresF;      // Pressure float snapshot
  logic [31:0]           snapAinF;       // Current float snapshot
  logic [31:0]           snapAinValF;    // Validated float snapshot
  logic [15:0]           snapInt [3];    // Integer code snapshots
  logic signed [31:0]    encFixed [3];   // Encoder inputs
  logic                  encAvail [3];   // Encoder availability
  logic [15:0]           encCode [3];    // Encoder outputs

  // Handshake and address stepping
  assign reqReady   = (state_r == mbrm_pkg::ST_IDLE);
  assign reqAccept  = reqValid && reqReady;
  assign curAddr    = req_r.addr + cnt_r;
  assign lastWord   = (cnt_r == req_r.qty - mbrm_pkg::QTY_MIN);
  assign ainInRange = (ainFixed >= mbrm_pkg::AIN_MIN_Q) && (ainFixed <= mbrm_pkg::AIN_MAX_Q);

  // Integer encoder inputs: pressure, actual current, validated current
  assign encFixed[0] = pressureFixed;
  assign encFixed[1] = ainFixed;
  assign encFixed[2] = ainFixed;
  assign encAvail[0] = pressureAvail;
  assign encAvail[1] = ainAvail;
  assign encAvail[2] = ainAvail && ainInRange;

  // One scaled encoder per integer register
  generate
    for (genvar g = 0; g < 3; g++)
    begin : gen_enc
      mbrm_int16_encode #(
        .SCALE   (g == 0 ? mbrm_pkg::SCALE_PRESS : mbrm_pkg::SCALE_AIN)
      ) u_enc (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .fixedIn (encFixed[g]),
        .avail   (encAvail[g]),
        .codeOut (encCode[g])
      );
    end
  endgenerate

  // Decode the request: unit routing and function support
  always_comb
  begin
    state_nxt   = mbrm_pkg::ST_EXC;
    excCode_nxt = mbrm_pkg::EXC_ILL_FUNC;
    if (req.unit == mbrm_pkg::UNIT_XMTR)
    begin
      if (req.func == mbrm_pkg::FC_READ_HOLD)
      begin
        // Local read: quantity bounds first
        if (req.qty < mbrm_pkg::QTY_MIN || req.qty > mbrm_pkg::QTY_MAX)
          excCode_nxt = mbrm_pkg::EXC_ILL_VALUE;
        else
          state_nxt = mbrm_pkg::ST_CHECK;
      end
      else if (req.func == mbrm_pkg::FC_DEV_IDENT)
      begin
        // Identification only with the right subcode
        if (req.meiType == mbrm_pkg::MEI_DEV_IDENT)
          state_nxt = mbrm_pkg::ST_IDENT;
        else
          excCode_nxt = mbrm_pkg::EXC_ILL_VALUE;
      end
    end
    else if (req.unit == mbrm_pkg::UNIT_PROBE1 || req.unit == mbrm_pkg::UNIT_PROBE2)
    begin
      // Probes get register reads only, never identification
      if (req.func == mbrm_pkg::FC_READ_HOLD)
        state_nxt = mbrm_pkg::ST_PROBE;
    end
    else
      excCode_nxt = mbrm_pkg::EXC_NO_PATH;
  end

  // Register lookup for the current word; all are read only
  always_comb
  begin
    hitOk   = 1'b0;
    hitWord = 16'h0000;
    case (curAddr)
      mbrm_pkg::ADDR_PRESS_F:
      begin
        hitOk   = baroFitted;
        hitWord = snapPresF[15:0];
      end
      mbrm_pkg::ADDR_PRESS_F + mbrm_pkg::ADDR_STEP:
      begin
        hitOk   = baroFitted;
        hitWord = snapPresF[31:16];
      end
      mbrm_pkg::ADDR_AIN_ACT_F:
      begin
        hitOk   = analogFitted;
        hitWord = snapAinF[15:0];
      end
      mbrm_pkg::ADDR_AIN_ACT_F + mbrm_pkg::ADDR_STEP:
      begin
        hitOk   = analogFitted;
        hitWord = snapAinF[31:16];
      end
      mbrm_pkg::ADDR_AIN_VAL_F:
      begin
        hitOk   = analogFitted;
        hitWord = snapAinValF[15:0];
      end
      mbrm_pkg::ADDR_AIN_VAL_F + mbrm_pkg::ADDR_STEP:
      begin
        hitOk   = analogFitted;
        hitWord = snapAinValF[31:16];
      end
      mbrm_pkg::ADDR_PRESS_I:
      begin
        hitOk   = baroFitted;
        hitWord = snapInt[0];
      end
      mbrm_pkg::ADDR_AIN_ACT_I:
      begin
        hitOk   = analogFitted;
        hitWord = snapInt[1];
      end
      mbrm_pkg::ADDR_AIN_VAL_I:
      begin
        hitOk   = analogFitted;
        hitWord = snapInt[2];
      end
      default:
      begin
        hitOk   = 1'b0;
        hitWord = 16'h0000;
      end
    endcase
  end

  // Identification table
  always_comb
  begin
    case (cnt_r[1:0])
      2'b00:   idWord = mbrm_pkg::ID_VENDOR;
      2'b01:   idWord = mbrm_pkg::ID_PRODUCT;
      default: idWord = mbrm_pkg::ID_REVISION;
    endcase
  end

  // State and word counter
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= mbrm_pkg::ST_IDLE;
      cnt_r   <= 16'h0000;
    end
    else
    begin
      case (state_r)
        mbrm_pkg::ST_IDLE:
        begin
          cnt_r <= 16'h0000;
          if (reqAccept)
            state_r <= state_nxt;
        end
        mbrm_pkg::ST_CHECK:
        begin
          // Every word must be served before any data goes out
          if (!hitOk)
            state_r <= mbrm_pkg::ST_EXC;
          else if (lastWord)
          begin
            state_r <= mbrm_pkg::ST_SEND;
            cnt_r   <= 16'h0000;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        mbrm_pkg::ST_SEND:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (lastWord)
            state_r <= mbrm_pkg::ST_IDLE;
        end
        mbrm_pkg::ST_IDENT:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == mbrm_pkg::ID_WORDS - 16'h0001)
            state_r <= mbrm_pkg::ST_IDLE;
        end
        mbrm_pkg::ST_PROBE:
        begin
          // Probe answer ends with its last word or an exception
          if (probeRspValid && (probeRsp.last || probeRsp.exc))
            state_r <= mbrm_pkg::ST_IDLE;
        end
        mbrm_pkg::ST_EXC:
          state_r <= mbrm_pkg::ST_IDLE;
        default:
          state_r <= mbrm_pkg::ST_IDLE;
      endcase
    end
  end

  // Request and exception code latch
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_r     <= '0;
      excCode_r <= 8'h00;
    end
    else if (reqAccept)
    begin
      req_r     <= req;
      excCode_r <= excCode_nxt;
    end
    else if (state_r == mbrm_pkg::ST_CHECK && !hitOk)
      excCode_r <= mbrm_pkg::EXC_ILL_ADDR;
  end

  // Snapshot on accept so both halves of a value are coherent
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      snapPresF   <= mbrm_pkg::FLOAT_NAN;
      snapAinF    <= mbrm_pkg::FLOAT_NAN;
      snapAinValF <= mbrm_pkg::FLOAT_NAN;
      snapInt     <= '{default: mbrm_pkg::CODE_NA};
    end
    else if (reqAccept)
    begin
      snapPresF   <= pressureAvail ? pressureFloat : mbrm_pkg::FLOAT_NAN;
      snapAinF    <= ainAvail ? ainFloat : mbrm_pkg::FLOAT_NAN;
      snapAinValF <= (ainAvail && ainInRange) ? ainFloat : mbrm_pkg::FLOAT_NAN;
      snapInt     <= encCode;
    end
  end

  // Answer word output
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rspValid <= 1'b0;
      rsp      <= '0;
    end
    else
    begin
      rspValid <= 1'b0;
      rsp      <= '0;
      case (state_r)
        mbrm_pkg::ST_SEND:
        begin
          rspValid <= 1'b1;
          rsp      <= '{data: hitWord, last: lastWord, exc: 1'b0};
        end
        mbrm_pkg::ST_IDENT:
        begin
          rspValid <= 1'b1;
          rsp      <= '{data: idWord, last: (cnt_r == mbrm_pkg::ID_WORDS - 16'h0001),
                        exc: 1'b0};
        end
        mbrm_pkg::ST_PROBE:
        begin
          // Idle probe lines must not leak onto the answer word
          rspValid <= probeRspValid;
          if (probeRspValid)
            rsp <= probeRsp;
        end
        mbrm_pkg::ST_EXC:
        begin
          rspValid <= 1'b1;
          rsp      <= '{data: {8'h00, excCode_r}, last: 1'b1, exc: 1'b1};
        end
        default:
        begin
          rspValid <= 1'b0;
          rsp      <= '0;
        end
      endcase
    end
  end

  // Probe forwarding, one pulse per routed read
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      probeReqValid <= 1'b0;
      probeReq      <= '0;
    end
    else
    begin
      probeReqValid <= reqAccept && (state_nxt == mbrm_pkg::ST_PROBE);
      if (reqAccept)
        probeReq <= '{sel: (req.unit == mbrm_pkg::UNIT_PROBE2), addr: req.addr, qty: req.qty};
    end
  end

  property p_probe_route;
    @(posedge clk_sys) disable iff (!reset_n)
    reqAccept && req.unit == 8'hF1 && req.func == 8'h03 |=> probeReqValid && !probeReq.sel;
  endproperty
  a_probe_route: assert property (p_probe_route) else $error("unit 241 not routed");

  property p_ident_xmtr;
    @(posedge clk_sys) disable iff (!reset_n)
    reqAccept && req.func == 8'h2B && req.unit != 8'hF0
      |=> state_r == mbrm_pkg::ST_EXC ##1 rspValid && rsp.exc;
  endproperty
  a_ident_xmtr: assert property (p_ident_xmtr) else $error("identification off unit 240");

  property p_bad_func;
    @(posedge clk_sys) disable iff (!reset_n)
    reqAccept && req.unit == 8'hF0 && req.func != 8'h03 && req.func != 8'h2B
      |=> ##1 rspValid && rsp.exc && rsp.data[7:0] == 8'h01 && rsp.last;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("no illegal function answer");

  property p_not_fitted;
    @(posedge clk_sys) disable iff (!reset_n)
    state_r == mbrm_pkg::ST_CHECK && curAddr == 16'h002A && !baroFitted
      |=> ##1 rspValid && rsp.exc && rsp.data[7:0] == 8'h02;
  endproperty
  a_not_fitted: assert property (p_not_fitted) else $error("unfitted pressure served");

  property p_low_word;
    @(posedge clk_sys) disable iff (!reset_n)
    state_r == mbrm_pkg::ST_SEND && curAddr == 16'h002A |=> rsp.data == snapPresF[15:0];
  endproperty
  a_low_word: assert property (p_low_word) else $error("pressure low word misplaced");

  property p_high_word;
    @(posedge clk_sys) disable iff (!reset_n)
    state_r == mbrm_pkg::ST_SEND && curAddr == 16'h002B |=> rsp.data == snapPresF[31:16];
  endproperty
  a_high_word: assert property (p_high_word) else $error("pressure high word misplaced");

  property p_valid_nan;
    @(posedge clk_sys) disable iff (!reset_n)
    reqAccept && !ainInRange |=> snapAinValF == 32'h7FC0_0000;
  endproperty
  a_valid_nan: assert property (p_valid_nan) else $error("out-of-window current not NaN");

  property p_bad_addr;
    @(posedge clk_sys) disable iff (!reset_n)
    state_r == mbrm_pkg::ST_CHECK && !hitOk |=> ##1 rspValid && rsp.exc && !$past(rspValid);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped address not refused");

endmodule // mbrm_register_map
`default_nettype wire

/* File: dv/mbrm_probe_model.sv */
// Behavioural probe answering forwarded register reads
`timescale 1ns/1ps
`default_nettype none
module mbrm_probe_model (
  // Clock, reset and pacing
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  input  wire logic                      slow,
  // Forwarded read and answer words
  input  wire logic                      probeReqValid,
  input  wire mbrm_pkg::mbrm_probe_req_t probeReq,
  output logic                           probeRspValid,
  output mbrm_pkg::mbrm_rsp_t            probeRsp
);
  logic [15:0] left_r;  // Words still owed
  logic [15:0] addr_r;  // Next word, terminal in bit 12
  logic [2:0]  wait_r;  // Cycles before next word
  // Answers each read with one word per register, idle lines toggled
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_r        <= 16'h0000;
      addr_r        <= 16'h0000;
      wait_r        <= 3'h0;
      probeRspValid <= 1'b0;
      probeRsp      <= '0;
    end
    else
    begin
      probeRspValid <= 1'b0;
      probeRsp      <= ~probeRsp;
      if (probeReqValid)
      begin
        left_r <= probeReq.qty;
        addr_r <= probeReq.addr | {3'h0, probeReq.sel, 12'h000};
        wait_r <= slow ? 3'h4 : 3'h0;
      end
      else if (left_r != 16'h0000 && wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
      else if (left_r != 16'h0000) // Register read of the probe
      begin
        probeRspValid <= 1'b1;
        probeRsp      <= '{addr_r, left_r == 16'h0001, 1'b0};
        addr_r        <= addr_r + 16'h0001;
        left_r        <= left_r - 16'h0001;
        wait_r        <= slow ? 3'h2 : 3'h0;
      end
    end
  end
endmodule // mbrm_probe_model
`default_nettype wire

/* File: dv/tb_mbrm_register_map.sv */
// Self-checking bench of the measurement register map
`timescale 1ns/1ps
`default_nettype none
module tb_mbrm_register_map;
  logic                      clk_sys, reset_n, slow;       // Clock, reset, probe pacing
  logic                      reqValid, reqReady, rspValid; // Request and answer strobes
  logic                      baroFitted, analogFitted;     // Fitted options
  logic                      pressureAvail, ainAvail;      // Availability
  logic [31:0]               pressureFloat, ainFloat;      // Float values
  logic signed [31:0]        pressureFixed, ainFixed;      // Q16.16 values
  logic                      probeReqValid, probeRspValid; // Probe strobes
  mbrm_pkg::mbrm_req_t       req;                          // Request
  mbrm_pkg::mbrm_rsp_t       rsp, probeRsp;                // Answer words
  mbrm_pkg::mbrm_probe_req_t probeReq;                     // Forwarded read
  mbrm_pkg::mbrm_rsp_t       q[$];                         // Collected answer words
  int                        n_errors, comparisons, cycles;
  mbrm_register_map i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .baroFitted(baroFitted),
    .analogFitted(analogFitted), .pressureFloat(pressureFloat), .pressureFixed(pressureFixed),
    .pressureAvail(pressureAvail), .ainFloat(ainFloat), .ainFixed(ainFixed),
    .ainAvail(ainAvail), .probeReqValid(probeReqValid), .probeReq(probeReq),
    .probeRspValid(probeRspValid), .probeRsp(probeRsp));
  mbrm_probe_model i_probe (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
    .probeReqValid(probeReqValid), .probeReq(probeReq), .probeRspValid(probeRspValid),
    .probeRsp(probeRsp));
  // Clock at 40 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Collects every answer word; cuts a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (rspValid)
      q.push_back(rsp);
    if (cycles == 3000)
    begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end
  // Compares one data word
  task automatic chkw(input mbrm_pkg::mbrm_rsp_t g, input logic [15:0] d, input logic l);
    comparisons++;
    if (g !== {d, l, 1'b0})
    begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, g, {d, l, 1'b0});
    end
  endtask
  // Sends one request and waits for its final word
  task automatic run(input logic [7:0] u, f, m, input logic [15:0] a, n);
    repeat (2) @(posedge clk_sys);
    q.delete();
    req      <= '{u, f, m, a, n};
    reqValid <= 1'b1;
    do @(posedge clk_sys); while (!reqReady); // Held until taken
    reqValid <= 1'b0;
    while (!(q.size() > 0 && (q[$].last || q[$].exc))) // A hang ends at the cycle ceiling
      @(posedge clk_sys);
  endtask
  // Sends a request that must be refused and compares the code
  task automatic exc(input logic [7:0] u, f, m, input logic [15:0] a, n, input logic [7:0] c);
    run(u, f, m, a, n);
    comparisons++;
    if (q.size() != 1 || {q[0].data[7:0], q[0].last, q[0].exc} !== {c, 2'b11})
    begin
      n_errors++;
      $display("[ERR] %0t refusal %h expected code %h", $time, q[0], c);
    end
  endtask
  task automatic t_float();
    run(8'hF0, 8'h03, 8'h0E, 16'h002A, 16'h0002); // Whole value in one read
    chkw(q[0], 16'h5000, 1'b0);
    chkw(q[1], 16'h447D, 1'b1);
    $display("float test done");
  endtask
  task automatic t_int();
    logic [31:0] fx [5] = '{32'h03F5_4000, 32'h0CCD_0000, 32'hFFFF_0000, 32'hF333_0000, 32'h0};
    logic [15:0] ex [5] = '{16'h2794, 16'h7FFF, 16'hFFF6, 16'h8001, 16'h8000};
    for (int k = 0; k < 5; k++)
    begin
      pressureFixed <= fx[k];
      pressureAvail <= (k != 4);
      run(8'hF0, 8'h03, 8'h0E, 16'h0115, 16'h0001);
      chkw(q[0], ex[k], 1'b1);
    end
    pressureAvail <= 1'b1;
    $display("integer test done");
  endtask
  task automatic t_ain();
    run(8'hF0, 8'h03, 8'h0E, 16'h0034, 16'h0004);
    chkw(q[0], 16'h0000, 1'b0);
    chkw(q[1], 16'h4000, 1'b0);
    chkw(q[2], 16'h0000, 1'b0);
    chkw(q[3], 16'h7FC0, 1'b1);
    run(8'hF0, 8'h03, 8'h0E, 16'h011A, 16'h0002);
    chkw(q[0], 16'h07D0, 1'b0);
    chkw(q[1], 16'h8000, 1'b1);
    ainFixed <= 32'sh0014_8000;
    run(8'hF0, 8'h03, 8'h0E, 16'h011A, 16'h0002);
    chkw(q[1], 16'h5014, 1'b1);
    $display("analog test done");
  endtask
  task automatic t_exc();
    exc(8'hF0, 8'h06, 8'h0E, 16'h002A, 16'h0001, 8'h01);
    exc(8'hF0, 8'h2B, 8'h0D, 16'h0000, 16'h0000, 8'h03);
    exc(8'hF0, 8'h03, 8'h0E, 16'h002A, 16'h0000, 8'h03);
    exc(8'hF0, 8'h03, 8'h0E, 16'h002A, 16'h007E, 8'h03);
    exc(8'hF0, 8'h03, 8'h0E, 16'h0029, 16'h0002, 8'h02);
    exc(8'hF1, 8'h2B, 8'h0E, 16'h0000, 16'h0000, 8'h01);
    exc(8'h05, 8'h03, 8'h0E, 16'h002A, 16'h0001, 8'h0A);
    baroFitted <= 1'b0;
    exc(8'hF0, 8'h03, 8'h0E, 16'h002A, 16'h0002, 8'h02);
    baroFitted <= 1'b1;
    analogFitted <= 1'b0;
    exc(8'hF0, 8'h03, 8'h0E, 16'h011A, 16'h0001, 8'h02);
    analogFitted <= 1'b1;
    $display("refusal test done");
  endtask
  task automatic t_ident();
    run(8'hF0, 8'h2B, 8'h0E, 16'h0000, 16'h0000);
    chkw(q[0], mbrm_pkg::ID_VENDOR, 1'b0);
    chkw(q[1], mbrm_pkg::ID_PRODUCT, 1'b0);
    chkw(q[2], mbrm_pkg::ID_REVISION, 1'b1);
    $display("identification test done");
  endtask
  task automatic t_probe();
    run(8'hF1, 8'h03, 8'h0E, 16'h0010, 16'h0002);
    chkw(q[0], 16'h0010, 1'b0);
    chkw(q[1], 16'h0011, 1'b1);
    slow <= 1'b1;
    run(8'hF2, 8'h03, 8'h0E, 16'h0020, 16'h0001);
    chkw(q[0], 16'h1020, 1'b1);
    $display("probe test done");
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic test_done();
    $display("Counts: %0d mismatches, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {reset_n, slow, reqValid, n_errors, comparisons, cycles} = '0;
    {baroFitted, analogFitted, pressureAvail, ainAvail} = 4'hF;
    {pressureFloat, ainFloat} = {32'h447D_5000, 32'h4000_0000};
    {pressureFixed, ainFixed} = {32'sh03F5_4000, 32'sh0002_0000};
    req = '0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_float();
    t_int();
    t_ain();
    t_exc();
    t_ident();
    t_probe();
    test_done();
  end
endmodule // tb_mbrm_register_map
`default_nettype wire
